// [low_freq_osc_control.sv]
// top: axi4-lite register slave and control of two 32 kHz oscillators
// assumes ulp_tick, xosc_tick and iosc_tick are one-cycle pulses on aclk
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module low_freq_osc_control (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,

    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,

    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,

    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,

    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,

    input wire logic ulp_tick,
    input wire logic xosc_tick,
    input wire logic iosc_tick,

    input wire logic standby,
    input wire logic ext_crystal_osc_req,
    input wire logic int_slow_osc_req,

    output logic ext_crystal_osc_run,
    output logic int_slow_osc_run,
    output logic auto_amplitude_en,
    output logic crystal_pad_sel,
    output logic ext_slow_clock_out_en,
    output logic int_slow_clock_out_en,
    output logic [6:0] trim_value,
    output logic crystal_ready_flag,
    output logic int_slow_osc_ready_flag
);
    logic [15:0] ext_crystal_osc_ctrl;
    logic [15:0] next_ext_crystal_osc_ctrl;

    logic [31:0] int_slow_osc_ctrl;
    logic [31:0] next_int_slow_osc_ctrl;

    logic [7:0] awaddr_q;
    logic [7:0] next_awaddr_q;

    logic aw_have;
    logic next_aw_have;

    logic [31:0] wdata_q;
    logic [31:0] next_wdata_q;

    logic [3:0] wstrb_q;
    logic [3:0] next_wstrb_q;

    logic w_have;
    logic next_w_have;

    logic bvalid;
    logic next_bvalid;

    logic [1:0] bresp;
    logic [1:0] next_bresp;

    logic rvalid;
    logic next_rvalid;

    logic [31:0] rdata;
    logic [31:0] next_rdata;

    logic [1:0] rresp;
    logic [1:0] next_rresp;

    logic [31:0] bmask;
    logic [31:0] merged;
    logic do_write;
    logic xosc_ready;
    logic iosc_ready;

    assign s_axi_awready = !aw_have && !bvalid;
    assign s_axi_wready = !w_have && !bvalid;
    assign s_axi_arready = !rvalid;

    assign s_axi_bvalid = bvalid;
    assign s_axi_bresp = bresp;
    assign s_axi_rvalid = rvalid;
    assign s_axi_rdata = rdata;
    assign s_axi_rresp = rresp;

    assign do_write = aw_have && w_have && !bvalid;

    always_comb
    begin
        next_awaddr_q = awaddr_q;
        next_aw_have = aw_have;
        next_wdata_q = wdata_q;
        next_wstrb_q = wstrb_q;
        next_w_have = w_have;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_ext_crystal_osc_ctrl = ext_crystal_osc_ctrl;
        next_int_slow_osc_ctrl = int_slow_osc_ctrl;
        bmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
        merged = 32'h0000_0000;

        if (s_axi_awvalid && s_axi_awready)
        begin
            next_awaddr_q = s_axi_awaddr;
            next_aw_have = 1'b1;
        end

        if (s_axi_wvalid && s_axi_wready)
        begin
            next_wdata_q = s_axi_wdata;
            next_wstrb_q = s_axi_wstrb;
            next_w_have = 1'b1;
        end

        if (do_write)
        begin
            next_aw_have = 1'b0;
            next_w_have = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = 2'b00;

            case ({awaddr_q[7:2], 2'b00})
                lfoc_pkg::ext_crystal_osc_ctrl_off:
                begin
                    if (!ext_crystal_osc_ctrl[lfoc_pkg::config_lock_bit]) // [R1] [R17]
                    begin
                        merged = ({16'h0000, ext_crystal_osc_ctrl} & ~bmask)
                            | (wdata_q & bmask);
                        next_ext_crystal_osc_ctrl = merged[15:0] & lfoc_pkg::xosc_wmask;
                    end
                end

                lfoc_pkg::int_slow_osc_ctrl_off:
                begin
                    if (!int_slow_osc_ctrl[lfoc_pkg::config_lock_bit]) // [R17]
                    begin
                        merged = (int_slow_osc_ctrl & ~bmask) | (wdata_q & bmask);
                        next_int_slow_osc_ctrl = merged & lfoc_pkg::iosc_wmask; // [R16]
                    end
                end

                lfoc_pkg::status_off:
                begin
                    next_bresp = 2'b00;
                end

                default:
                begin
                    next_bresp = 2'b10;
                end
            endcase
        end

        if (bvalid && s_axi_bready)
        begin
            next_bvalid = 1'b0;
        end
    end

    always_comb
    begin
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;

        if (s_axi_arvalid && s_axi_arready)
        begin
            next_rvalid = 1'b1;
            next_rresp = 2'b00;

            case ({s_axi_araddr[7:2], 2'b00})
                lfoc_pkg::ext_crystal_osc_ctrl_off:
                begin
                    next_rdata = {16'h0000, ext_crystal_osc_ctrl};
                end

                lfoc_pkg::int_slow_osc_ctrl_off:
                begin
                    next_rdata = int_slow_osc_ctrl;
                end

                lfoc_pkg::status_off:
                begin
                    next_rdata = {30'h0000_0000, iosc_ready, xosc_ready};
                end

                default:
                begin
                    next_rdata = 32'h0000_0000;
                    next_rresp = 2'b10;
                end
            endcase
        end
        else if (rvalid && s_axi_rready)
        begin
            next_rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ext_crystal_osc_ctrl <= lfoc_pkg::ext_crystal_osc_ctrl_rst; // [R13]
            int_slow_osc_ctrl <= lfoc_pkg::int_slow_osc_ctrl_rst; // [R14]

            awaddr_q <= 8'h00;
            aw_have <= 1'b0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            w_have <= 1'b0;

            bvalid <= 1'b0;
            bresp <= 2'b00;

            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= 2'b00;
        end
        else
        begin
            ext_crystal_osc_ctrl <= next_ext_crystal_osc_ctrl;
            int_slow_osc_ctrl <= next_int_slow_osc_ctrl;

            awaddr_q <= next_awaddr_q;
            aw_have <= next_aw_have;
            wdata_q <= next_wdata_q;
            wstrb_q <= next_wstrb_q;
            w_have <= next_w_have;

            bvalid <= next_bvalid;
            bresp <= next_bresp;

            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
        end
    end

    lfoc_run_policy u_xosc_policy (
        .enable(ext_crystal_osc_ctrl[lfoc_pkg::enable_bit]),
        .run_on_request(ext_crystal_osc_ctrl[lfoc_pkg::run_on_request_bit]),
        .run_in_standby(ext_crystal_osc_ctrl[lfoc_pkg::run_in_standby_bit]),
        .standby(standby),
        .clk_request(ext_crystal_osc_req),
        .run(ext_crystal_osc_run)
    );

    lfoc_run_policy u_iosc_policy (
        .enable(int_slow_osc_ctrl[lfoc_pkg::enable_bit]),
        .run_on_request(int_slow_osc_ctrl[lfoc_pkg::run_on_request_bit]),
        .run_in_standby(int_slow_osc_ctrl[lfoc_pkg::run_in_standby_bit]),
        .standby(standby),
        .clk_request(int_slow_osc_req),
        .run(int_slow_osc_run)
    );

    lfoc_startup #(
        .sync_cycles(lfoc_pkg::xosc_sync_cycles)
    ) u_xosc_startup (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(ext_crystal_osc_run),
        .length(lfoc_pkg::lfoc_xosc_len(
            ext_crystal_osc_ctrl[lfoc_pkg::startup_msb:lfoc_pkg::startup_lsb])), // [R3]
        .count_tick(ulp_tick), // [R2]
        .sync_tick(xosc_tick), // [R4]
        .ready(xosc_ready)
    );

    lfoc_startup #(
        .sync_cycles(lfoc_pkg::iosc_sync_cycles)
    ) u_iosc_startup (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(int_slow_osc_run),
        .length(lfoc_pkg::lfoc_iosc_len(
            int_slow_osc_ctrl[lfoc_pkg::startup_msb:lfoc_pkg::startup_lsb])), // [R15]
        .count_tick(iosc_tick),
        .sync_tick(iosc_tick),
        .ready(iosc_ready)
    );

    assign auto_amplitude_en = ext_crystal_osc_ctrl[lfoc_pkg::auto_amplitude_en_bit]; // [R9]
    assign crystal_pad_sel = ext_crystal_osc_ctrl[lfoc_pkg::crystal_pad_sel_bit]; // [R11]
    assign ext_slow_clock_out_en = ext_crystal_osc_ctrl[lfoc_pkg::xosc_out_en_bit]
        && xosc_ready; // [R10]

    assign int_slow_clock_out_en = int_slow_osc_ctrl[lfoc_pkg::int_out_en_bit] && iosc_ready;

    assign trim_value = int_slow_osc_ctrl[lfoc_pkg::trim_msb:lfoc_pkg::trim_lsb];
    assign crystal_ready_flag = xosc_ready;
    assign int_slow_osc_ready_flag = iosc_ready;
endmodule

// [lfoc_pkg.sv]
// package of register map, field layout, reset values and start-up tables
// assumes a 100 MHz system clock and an ultra-low-power 32 kHz tick input
// Notes on behaviour
// [R1] lock bit twelve blocks later crystal writes
// [R2] crystal start-up counter counts ultra-low-power ticks
// [R3] crystal start-up codes select 1 to 131072
// [R4] three crystal cycles before crystal ready
// [R5] on-demand runs only while requested
// [R6] without on-demand run whenever enabled
// [R7] standby without run-in-standby stops oscillator
// [R8] standby with run-in-standby keeps normal policy
// [R9] bit five drives automatic amplitude control
// [R10] bit three gates slow clock output
// [R11] bit two selects crystal or external pad
// [R12] bit one enables oscillator under policy
// [R13] crystal register 0x14 resets 0x0080
// [R14] internal register 0x18 resets 0x003F0080
// [R15] internal start-up 3 to 130, two sync
// [R16] software writes internal trim value itself
// [R17] lock stays set until reset
package lfoc_pkg;
    localparam logic [7:0] ext_crystal_osc_ctrl_off = 8'h14;
    localparam logic [7:0] int_slow_osc_ctrl_off = 8'h18;
    localparam logic [7:0] status_off = 8'h1c;
    localparam logic [15:0] ext_crystal_osc_ctrl_rst = 16'h0080;
    localparam logic [31:0] int_slow_osc_ctrl_rst = 32'h003f_0080;
    localparam int trim_lsb = 16;
    localparam int trim_msb = 22;
    localparam int config_lock_bit = 12;
    localparam int startup_lsb = 8;
    localparam int startup_msb = 10;
    localparam int run_on_request_bit = 7;
    localparam int run_in_standby_bit = 6;
    localparam int auto_amplitude_en_bit = 5;
    localparam int xosc_out_en_bit = 3;
    localparam int crystal_pad_sel_bit = 2;
    localparam int int_out_en_bit = 2;
    localparam int enable_bit = 1;
    localparam logic [15:0] xosc_wmask = 16'h17ee;
    localparam logic [31:0] iosc_wmask = 32'h007f_17c6;
    localparam int cnt_w = 18;
    localparam int xosc_sync_cycles = 3;
    localparam int iosc_sync_cycles = 2;
    typedef logic [cnt_w-1:0] lfoc_cnt_t;
    function automatic lfoc_cnt_t lfoc_xosc_len(input logic [2:0] code);
        lfoc_cnt_t r;
        r = 18'h0_0001;
        case (code)
            3'h0: r = 18'h0_0001;
            3'h1: r = 18'h0_0020;
            3'h2: r = 18'h0_0800;
            3'h3: r = 18'h0_1000;
            3'h4: r = 18'h0_4000;
            3'h5: r = 18'h0_8000;
            3'h6: r = 18'h1_0000;
            default: r = 18'h2_0000;
        endcase
        return r;
    endfunction
    function automatic lfoc_cnt_t lfoc_iosc_len(input logic [2:0] code);
        lfoc_cnt_t r;
        r = 18'h0_0003;
        case (code)
            3'h0: r = 18'h0_0003;
            3'h1: r = 18'h0_0004;
            3'h2: r = 18'h0_0006;
            3'h3: r = 18'h0_000a;
            3'h4: r = 18'h0_0012;
            3'h5: r = 18'h0_0022;
            3'h6: r = 18'h0_0042;
            default: r = 18'h0_0082;
        endcase
        return r;
    endfunction
endpackage

// [lfoc_startup.sv]
// start-up counter and sync delay for one oscillator
// assumes tick inputs are one-cycle pulses synchronous to aclk
`timescale 1ns/1ps
module lfoc_startup #(
    parameter int sync_cycles = 3
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic run,
    input wire logic [17:0] length,
    input wire logic count_tick,
    input wire logic sync_tick,
    output logic ready
);
    if (sync_cycles < 1 || sync_cycles > 7)
    begin
        $error("sync_cycles out of range");
    end
    typedef enum logic [1:0] {lfoc_idle_s = 2'b00, lfoc_count_s = 2'b01,
        lfoc_sync_s = 2'b11, lfoc_ready_s = 2'b10} lfoc_st_t;
    lfoc_st_t st;
    lfoc_st_t next_st;
    logic [17:0] cnt;
    logic [17:0] next_cnt;
    always_comb
    begin
        next_st = st;
        next_cnt = cnt;
        case (st)
            lfoc_idle_s:
            begin
                next_cnt = 18'h0_0000;
                if (run)
                begin
                    next_st = lfoc_count_s;
                end
            end
            lfoc_count_s:
            begin
                if (count_tick)
                begin
                    next_cnt = cnt + 18'h0_0001; // [R2]
                    if (cnt + 18'h0_0001 >= length)
                    begin
                        next_st = lfoc_sync_s; // [R3] [R15]
                        next_cnt = 18'h0_0000;
                    end
                end
            end
            lfoc_sync_s:
            begin
                if (sync_tick)
                begin
                    next_cnt = cnt + 18'h0_0001;
                    if (cnt + 18'h0_0001 >= 18'(sync_cycles))
                    begin
                        next_st = lfoc_ready_s; // [R4] [R15]
                    end
                end
            end
            lfoc_ready_s:
            begin
                next_cnt = cnt;
            end
            default:
            begin
                next_st = lfoc_idle_s;
            end
        endcase
        if (!run)
        begin
            next_st = lfoc_idle_s;
            next_cnt = 18'h0_0000;
        end
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st <= lfoc_idle_s;
            cnt <= 18'h0_0000;
        end
        else
        begin
            st <= next_st;
            cnt <= next_cnt;
        end
    end
    assign ready = (st == lfoc_ready_s);
endmodule

// [lfoc_run_policy.sv]
// run decision for one oscillator from enable, on-demand and standby
// assumes request and standby are levels synchronous to aclk
`timescale 1ns/1ps
module lfoc_run_policy (
    input wire logic enable,
    input wire logic run_on_request,
    input wire logic run_in_standby,
    input wire logic standby,
    input wire logic clk_request,
    output logic run
);
    always_comb
    begin
        run = 1'b0;
        if (enable) // [R12]
        begin
            if (standby && !run_in_standby)
            begin
                run = 1'b0; // [R7]
            end
            else if (run_on_request)
            begin
                run = clk_request; // [R5] [R8]
            end
            else
            begin
                run = 1'b1; // [R6] [R8]
            end
        end
    end
endmodule

// [lfoc_osc_model.sv]
// tick source model: free ultra-low-power tick plus crystal and internal ticks
// assumes run levels from the control block, ticks are one-cycle pulses on aclk
`timescale 1ns/1ps
module lfoc_osc_model #(
    parameter int ulp_period = 7,
    parameter int crystal_period = 2,
    parameter int int_period = 3
) (
    input wire logic aclk,
    input wire logic crystal_on,
    input wire logic int_on,
    output logic ulp_tick,
    output logic crystal_tick,
    output logic int_tick
);
    int cu = 0;
    int cx = 0;
    int ci = 0;
    always @(posedge aclk)
    begin
        cu <= (cu + 1) % ulp_period;
        cx <= crystal_on ? (cx + 1) % crystal_period : 0;
        ci <= int_on ? (ci + 1) % int_period : 0;
    end
    // slower than the crystal so the sync ticks sit between two counter ticks
    assign ulp_tick = (cu == ulp_period - 1);
    // stopped sources give no ticks
    assign crystal_tick = crystal_on && (cx == crystal_period - 1);
    assign int_tick = int_on && (ci == int_period - 1);
endmodule

// [lfoc_assertions.sv]
// checker of the oscillator control top ports
// assumes one clock domain, bound to the top module by name
`timescale 1ns/1ps
module lfoc_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic xosc_tick,
    input wire logic iosc_tick,
    input wire logic standby,
    input wire logic ext_crystal_osc_run,
    input wire logic int_slow_osc_run,
    input wire logic auto_amplitude_en,
    input wire logic crystal_pad_sel,
    input wire logic ext_slow_clock_out_en,
    input wire logic int_slow_clock_out_en,
    input wire logic [6:0] trim_value,
    input wire logic crystal_ready_flag,
    input wire logic int_slow_osc_ready_flag
);
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    logic [15:0] icnt;
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !int_slow_osc_run)
            icnt <= '0;
        else if (iosc_tick && !int_slow_osc_ready_flag)
            icnt <= icnt + 16'h0001;
    end
    a_reset_values: assert property ($rose(aresetn) |-> trim_value == 7'h3f
        && !crystal_pad_sel && !auto_amplitude_en && !ext_crystal_osc_run && !int_slow_osc_run)
        else $error("reset state wrong");
    a_crystal_out_gate: assert property (ext_slow_clock_out_en |-> crystal_ready_flag)
        else $error("crystal output without ready");
    a_int_out_gate: assert property (int_slow_clock_out_en |-> int_slow_osc_ready_flag)
        else $error("internal output without ready");
    a_crystal_sync_tick: assert property ($rose(crystal_ready_flag) |->
        $past(xosc_tick) && $past(ext_crystal_osc_run)) else $error("crystal ready off tick");
    a_crystal_ready_drop: assert property (!ext_crystal_osc_run |=> !crystal_ready_flag)
        else $error("crystal ready while stopped");
    a_int_ready_drop: assert property (!int_slow_osc_run |=> !int_slow_osc_ready_flag)
        else $error("internal ready while stopped");
    a_int_sync_tick: assert property ($rose(int_slow_osc_ready_flag) |-> $past(iosc_tick))
        else $error("internal ready off tick");
    a_int_startup_min: assert property ($rose(int_slow_osc_ready_flag) |-> icnt >= 16'h0005)
        else $error("internal start-up too short");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:3] s_axi_bvalid) else $error("write answer late");
    c_crystal_ready: cover property ($rose(crystal_ready_flag));
    c_int_ready: cover property ($rose(int_slow_osc_ready_flag));
    c_standby_run: cover property (standby && int_slow_osc_run);
endmodule
bind low_freq_osc_control lfoc_checker chk_i (.*);

// [tb_top.sv]
// testbench: registers, run policy, start-up timing and lock of the oscillator control
// assumes the tick model drives the three tick inputs
`timescale 1ns/1ps
module tb_top;
    localparam logic [7:0] cra = lfoc_pkg::ext_crystal_osc_ctrl_off;
    localparam logic [7:0] ira = lfoc_pkg::int_slow_osc_ctrl_off;
    logic aclk = 0;
    logic aresetn = 0;
    logic [7:0] s_axi_awaddr = '0;
    logic s_axi_awvalid = 0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_wvalid = 0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 0;
    logic [7:0] s_axi_araddr = '0;
    logic s_axi_arvalid = 0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 0;
    logic ulp_tick, xosc_tick, iosc_tick;
    logic standby = 0;
    logic ext_crystal_osc_req = 0;
    logic int_slow_osc_req = 0;
    logic ext_crystal_osc_run, int_slow_osc_run, auto_amplitude_en, crystal_pad_sel;
    logic ext_slow_clock_out_en, int_slow_clock_out_en, crystal_ready_flag;
    logic int_slow_osc_ready_flag;
    logic [6:0] trim_value;
    logic [1:0] resp;
    logic [31:0] rd;
    int n_errors = 0;
    int checks_done = 0;
    int nu = 0;
    int nx = 0;
    int ni = 0;
    int crystal_len[3] = '{1, 32, 2048};
    int int_len[8] = '{3, 4, 6, 10, 18, 34, 66, 130};

    always #5 aclk = ~aclk;

    low_freq_osc_control dut (.*);
    lfoc_osc_model partner (.aclk(aclk), .crystal_on(ext_crystal_osc_run),
        .int_on(int_slow_osc_run), .ulp_tick(ulp_tick), .crystal_tick(xosc_tick),
        .int_tick(iosc_tick));

    // start-up tick counts, cleared while stopped
    always @(posedge aclk)
    begin
        if (!ext_crystal_osc_run)
        begin
            nu <= 0;
            nx <= 0;
        end
        else if (!crystal_ready_flag && ulp_tick)
        begin
            nu <= nu + 1;
            nx <= 0;
        end
        else if (!crystal_ready_flag && xosc_tick)
            nx <= nx + 1;
        ni <= !int_slow_osc_run ? 0 : ni + int'(iosc_tick && !int_slow_osc_ready_flag);
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic report_and_stop;
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic guard(input int n);
        if (n >= 2000)
        begin
            n_errors++;
            $display("BAD wait expected answer seen timeout");
            report_and_stop;
        end
    endtask

    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        int n;
        logic aw_ok;
        logic w_ok;
        n = 0;
        aw_ok = 0;
        w_ok = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do
        begin
            @(posedge aclk);
            n++;
            guard(n);
            aw_ok = aw_ok || s_axi_awready;
            w_ok = w_ok || s_axi_wready;
            s_axi_awvalid <= !aw_ok;
            s_axi_wvalid <= !w_ok;
        end while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 0;
    endtask

    task automatic axr(input logic [7:0] a);
        int n;
        logic ar_ok;
        n = 0;
        ar_ok = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do
        begin
            @(posedge aclk);
            n++;
            guard(n);
            ar_ok = ar_ok || s_axi_arready;
            s_axi_arvalid <= !ar_ok;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 0;
    endtask

    // c: enable, on-request, run-in-standby, standby, request
    function automatic logic run_exp(input logic [4:0] c);
        return c[0] && !(c[3] && !c[2]) && (!c[1] || c[4]);
    endfunction

    task automatic startup(input logic intl, input logic [2:0] code, input int len);
        int n;
        n = 0;
        axw(intl ? ira : cra, 32'h0000_0000);
        axw(intl ? ira : cra, {21'h0, code, 8'h0e});
        while (!(intl ? int_slow_osc_ready_flag : crystal_ready_flag))
        begin
            @(posedge aclk);
            n++;
            guard(n / 8);
        end
        @(negedge aclk);
        if (intl)
        begin
            chk("internal start ticks", 1, 32'(ni >= len + 2 && ni <= len + 3));
            chk("internal out en", 1, 32'(int_slow_clock_out_en));
        end
        else
        begin
            chk("crystal start ticks", 1, 32'(nu >= len && nu <= len + 1));
            chk("crystal sync ticks", 3, nx);
            chk("crystal out en", 1, 32'(ext_slow_clock_out_en));
        end
    endtask

    initial
    begin
        logic [31:0] v;
        logic [4:0] c;
        logic [31:0] m;
        void'($urandom(51));
        repeat (12) @(posedge aclk);
        aresetn <= 1;
        axr(cra);
        chk("crystal reg reset", 32'h0000_0080, rd);
        axr(ira);
        chk("internal reg reset", 32'h003f_0080, rd);
        axr(8'h40);
        chk("unmapped read resp", 32'h0000_0002, {30'h0, resp});
        axw(8'h40, $urandom);
        chk("unmapped write resp", 32'h0000_0002, {30'h0, resp});
        for (int i = 0; i < 64; i++)
        begin
            c = i[4:0];
            v = $urandom & 32'h007f_072c;
            v[7] = c[1];
            v[6] = c[2];
            v[1] = c[0];
            axw(i[5] ? ira : cra, v);
            standby <= c[3];
            ext_crystal_osc_req <= c[4];
            int_slow_osc_req <= c[4];
            axr(i[5] ? ira : cra);
            m = i[5] ? lfoc_pkg::iosc_wmask : 32'(lfoc_pkg::xosc_wmask);
            chk("readback", v & m, rd);
            @(negedge aclk);
            if (!i[5])
            begin
                chk("crystal run", 32'(run_exp(c)), 32'(ext_crystal_osc_run));
                chk("amplitude", 32'(v[5]), 32'(auto_amplitude_en));
                chk("pad select", 32'(v[2]), 32'(crystal_pad_sel));
            end
            else
            begin
                chk("internal run", 32'(run_exp(c)), 32'(int_slow_osc_run));
                chk("trim", 32'(v[22:16]), 32'(trim_value));
            end
        end
        standby <= 0;
        for (int k = 0; k < 3; k++)
            startup(0, k[2:0], crystal_len[k]);
        for (int k = 0; k < 8; k++)
            startup(1, k[2:0], int_len[k]);
        axr(lfoc_pkg::status_off);
        chk("ready status", 32'h0000_0003, rd);
        axw(cra, 32'h0000_1026);
        axw(cra, 32'h0000_00c8);
        axr(cra);
        chk("locked crystal reg", 32'h0000_1026, rd);
        chk("locked pad select", 1, 32'(crystal_pad_sel));
        axw(ira, 32'h0055_1006);
        axw(ira, 32'h0011_0000);
        axr(ira);
        chk("locked internal reg", 32'h0055_1006, rd);
        chk("locked trim", 32'h0000_0055, 32'(trim_value));
        aresetn <= 0;
        repeat (12) @(posedge aclk);
        aresetn <= 1;
        axr(cra);
        chk("crystal reg after reset", 32'h0000_0080, rd);
        report_and_stop;
    end
endmodule
